// ===== logic/sdl_consts.vh
// Purpose: Shared constants of the six-channel DAC load sequencer
// Assumes: Included by bare name from the design files
// Notes:   Offsets are byte addresses on the APB bus
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH

`define SDL_DATA_W 10
`define SDL_CHAN_W 3
`define SDL_NUM_CHAN 6
`define SDL_LAST_CHAN 3'h5
`define SDL_SEQ_SEL 3'h7
`define SDL_SEQ_WORDS 3'h6

`define SDL_FIFO_DEPTH 32
`define SDL_FIFO_AW 5
`define SDL_FIFO_W 15

`define SDL_ADDR_W 8
`define SDL_OFS_CTRL 8'h00
`define SDL_OFS_STATUS 8'h04

`define SDL_CTRL_EO 0
`define SDL_CTRL_RL 1
`define SDL_CTRL_PD 2
`define SDL_CTRL_HOLD 3
`define SDL_CTRL_RST 4'h1

`define SDL_ST_ACT 0
`define SDL_ST_CHAN_LO 1
`define SDL_ST_OVF 4
`define SDL_ST_LVL_LO 5
`define SDL_ST_PD 11

`endif

// ===== logic/sdl_sync.v
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Each bit is a level; groups may skew by one cycle
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module sdl_sync #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sdl_sync

// ===== logic/sdl_fifo.v
// Purpose: Word FIFO with valid and ready on both sides
// Assumes: One clock; flush empties it in one cycle
// Notes:   Full is honest; a write while full is refused
`timescale 1ns/1ps
module sdl_fifo #(
    parameter W = 15,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire pclk,
    input wire presetn,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output reg [AW:0] level
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    wire do_wr;
    wire do_rd;

    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign out_data = mem[rptr_r];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    always @(posedge pclk) begin
        if (do_wr) begin
            mem[wptr_r] <= in_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            level <= {(AW+1){1'b0}};
        end else if (flush) begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            level <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (do_rd) begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                level <= level + 1'b1;
            end else if (do_rd && !do_wr) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule // sdl_fifo

// ===== logic/sdl_top.v
// Purpose: Load sequencer feeding six two-stage DAC channel latches
// Assumes: Pixel clock and strobes are pins, sampled on pclk
// Notes:   Pixel clock must be well below pclk/4 for edge detection
//          Power-down flushes the FIFO and zeroes both latch stages
//
// Notes on behaviour
// RULE1: One shared data bus feeds six channels
// RULE2: Master/slave latches update all outputs together
// RULE3: Sequencing starts after start_sequence, select all ones
// RULE4: Outputs update at first falling edge after transfer
// RULE5: Low right_left_select loads channels 0 up to 5
// RULE6: High right_left_select loads channels 5 down to 0
// RULE7: Ascending single device: word n to channel n
// RULE8: Even device captures rising, odd device captures falling
// RULE9: Controller clocks at half pixel rate, word per edge
// RULE10: Even/odd group maps words 2k or 2k+1
// RULE11: Controller gives separate starts, one common transfer
// RULE12: Static start and transfer: load selected channel each fall
// RULE13: Addressed load uses address sampled at prior rise
// RULE14: Controller respects output amplifier settling time
// RULE15: Power-down clears all data; resumes when released
// RULE16: Select 0..5 addresses channel; all ones sequences
// RULE17: Sequencer stops after six channels until next start
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "sdl_consts.vh"
module sdl_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SDL_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire pix_clk,
    input wire [`SDL_DATA_W-1:0] pixel_data,
    input wire start_sequence,
    input wire transfer_strobe,
    input wire [`SDL_CHAN_W-1:0] channel_select,
    output reg in_ready,
    output wire [`SDL_DATA_W-1:0] column_output_0,
    output wire [`SDL_DATA_W-1:0] column_output_1,
    output wire [`SDL_DATA_W-1:0] column_output_2,
    output wire [`SDL_DATA_W-1:0] column_output_3,
    output wire [`SDL_DATA_W-1:0] column_output_4,
    output wire [`SDL_DATA_W-1:0] column_output_5
);
    localparam PIN_W = `SDL_DATA_W + `SDL_CHAN_W + 3;

    wire [PIN_W-1:0] pins_s;
    wire clk_s;
    wire st_s;
    wire xf_s;
    wire [`SDL_CHAN_W-1:0] cs_s;
    wire [`SDL_DATA_W-1:0] data_s;
    reg clk_d_r;
    reg st_d_r;
    reg [3:0] ctrl_r;
    reg ovf_r;
    reg [`SDL_CHAN_W-1:0] addr_r;
    reg [`SDL_CHAN_W-1:0] chan_r;
    reg [`SDL_CHAN_W-1:0] left_r;
    reg seq_act_r;
    reg xfer_pend_r;
    reg [`SDL_DATA_W-1:0] st1_r [0:`SDL_NUM_CHAN-1];
    reg [`SDL_DATA_W-1:0] st2_r [0:`SDL_NUM_CHAN-1];

    wire eo;
    wire rl;
    wire pd;
    wire rise;
    wire fall;
    wire cap_edge;
    wire seq_sel;
    wire seq_load;
    wire addr_load;
    wire do_load;
    wire do_xfer;
    wire push;
    wire [`SDL_CHAN_W-1:0] load_ch;
    wire [`SDL_FIFO_W-1:0] push_word;
    wire f_in_ready;
    wire f_out_valid;
    wire f_out_ready;
    wire [`SDL_FIFO_W-1:0] f_out;
    wire [`SDL_FIFO_AW:0] f_level;
    wire q_load;
    wire q_xfer;
    wire [`SDL_CHAN_W-1:0] q_ch;
    wire [`SDL_DATA_W-1:0] q_data;
    wire apb_done;
    wire wr_ctrl;
    wire wr_status;
    wire hit;

    // First channel of a sequence, by direction
    function [`SDL_CHAN_W-1:0] first_chan;
        input dir;
        begin
            first_chan = dir ? `SDL_LAST_CHAN : {`SDL_CHAN_W{1'b0}};
        end
    endfunction

    // Register offset decode, shared by read and write paths
    function is_reg;
        input [`SDL_ADDR_W-1:0] a;
        input [`SDL_ADDR_W-1:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    // One synchroniser for all pins keeps data aligned with its clock
    sdl_sync #(
        .W(PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({pix_clk, start_sequence, transfer_strobe, channel_select,
            pixel_data}),
        .q(pins_s)
    );

    assign clk_s = pins_s[PIN_W-1];
    assign st_s = pins_s[PIN_W-2];
    assign xf_s = pins_s[PIN_W-3];
    assign cs_s = pins_s[`SDL_DATA_W+`SDL_CHAN_W-1:`SDL_DATA_W];
    assign data_s = pins_s[`SDL_DATA_W-1:0];

    assign eo = ctrl_r[`SDL_CTRL_EO];
    assign rl = ctrl_r[`SDL_CTRL_RL];
    assign pd = ctrl_r[`SDL_CTRL_PD];

    assign rise = clk_s & ~clk_d_r;
    assign fall = ~clk_s & clk_d_r;
    assign cap_edge = eo ? rise : fall; // [RULE8] [RULE9]
    assign seq_sel = (cs_s == `SDL_SEQ_SEL); // [RULE16]

    assign seq_load = seq_act_r & seq_sel & cap_edge; // [RULE1]
    // Direct and addressed loading share one path [RULE12] [RULE13]
    // Mode follows the address held at the rise, not the live select,
    // so a select change before the fall cannot cancel the load
    assign addr_load = st_s & fall &
                       (addr_r < `SDL_NUM_CHAN); // [RULE16]
    assign do_load = seq_load | addr_load;
    assign load_ch = seq_load ? chan_r : addr_r;
    assign do_xfer = fall & xfer_pend_r; // [RULE4]
    assign push = (do_load | do_xfer) & ~pd;
    assign push_word = {do_load, do_xfer, load_ch, data_s};

    // Edge history and transfer request; a strobe beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d_r <= 1'b0;
            st_d_r <= 1'b0;
            xfer_pend_r <= 1'b0;
        end else begin
            clk_d_r <= clk_s;
            st_d_r <= st_s;
            xfer_pend_r <= ~pd & ((xfer_pend_r & ~fall) | xf_s); // [RULE4]
        end
    end

    // Address for addressed loading is held from the rising edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= {`SDL_CHAN_W{1'b0}};
        end else if (rise) begin
            addr_r <= cs_s; // [RULE13]
        end
    end

    // Sequencer: six words, then idle until the next start
    // A start seen on a capture edge while idle arms only; that edge loads nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_act_r <= 1'b0;
            chan_r <= {`SDL_CHAN_W{1'b0}};
            left_r <= {`SDL_CHAN_W{1'b0}};
        end else if (pd) begin
            seq_act_r <= 1'b0; // [RULE15]
            chan_r <= {`SDL_CHAN_W{1'b0}};
            left_r <= {`SDL_CHAN_W{1'b0}};
        end else if (st_s && !st_d_r && seq_sel) begin
            seq_act_r <= 1'b1; // [RULE3]
            chan_r <= first_chan(rl); // [RULE5] [RULE6]
            left_r <= `SDL_SEQ_WORDS;
        end else if (seq_load) begin
            if (rl) begin
                chan_r <= chan_r - 1'b1; // [RULE6] [RULE10]
            end else begin
                chan_r <= chan_r + 1'b1; // [RULE5] [RULE7] [RULE10]
            end
            left_r <= left_r - 1'b1;
            if (left_r == 3'h1) begin
                seq_act_r <= 1'b0; // [RULE17]
            end
        end
    end

    // Decouples pin capture from latch update; hold bit stalls draining
    sdl_fifo #(
        .W(`SDL_FIFO_W),
        .DEPTH(`SDL_FIFO_DEPTH),
        .AW(`SDL_FIFO_AW)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(pd),
        .in_valid(push),
        .in_ready(f_in_ready),
        .in_data(push_word),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out),
        .level(f_level)
    );

    assign f_out_ready = ~ctrl_r[`SDL_CTRL_HOLD];
    assign q_load = f_out[`SDL_FIFO_W-1] & f_out_valid & f_out_ready;
    assign q_xfer = f_out[`SDL_FIFO_W-2] & f_out_valid & f_out_ready;
    assign q_ch = f_out[`SDL_DATA_W+`SDL_CHAN_W-1:`SDL_DATA_W];
    assign q_data = f_out[`SDL_DATA_W-1:0];

    // Two-stage latch per channel
    genvar k;
    generate
        for (k = 0; k < `SDL_NUM_CHAN; k = k + 1) begin : g_chan
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st1_r[k] <= {`SDL_DATA_W{1'b0}};
                    st2_r[k] <= {`SDL_DATA_W{1'b0}};
                end else if (pd) begin
                    st1_r[k] <= {`SDL_DATA_W{1'b0}}; // [RULE15]
                    st2_r[k] <= {`SDL_DATA_W{1'b0}};
                end else begin
                    if (q_load && q_ch == k) begin
                        st1_r[k] <= q_data; // [RULE1]
                    end
                    if (q_xfer) begin
                        // Word of the same edge is included [RULE2] [RULE12]
                        st2_r[k] <= (q_load && q_ch == k) ? q_data : st1_r[k];
                    end
                end
            end
        end
    endgenerate

    assign column_output_0 = st2_r[0];
    assign column_output_1 = st2_r[1];
    assign column_output_2 = st2_r[2];
    assign column_output_3 = st2_r[3];
    assign column_output_4 = st2_r[4];
    assign column_output_5 = st2_r[5];

    // APB slave: one wait state, then pready for one cycle
    // Read data is zero outside the answer, so nothing stale leaks
    assign apb_done = psel & penable & pready;
    assign hit = is_reg(paddr, `SDL_OFS_CTRL) |
                 is_reg(paddr, `SDL_OFS_STATUS);
    assign wr_ctrl = apb_done & pwrite & is_reg(paddr, `SDL_OFS_CTRL);
    assign wr_status = apb_done & pwrite & is_reg(paddr, `SDL_OFS_STATUS);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                if (is_reg(paddr, `SDL_OFS_CTRL)) begin
                    prdata <= {28'h000_0000, ctrl_r};
                end else if (is_reg(paddr, `SDL_OFS_STATUS)) begin
                    prdata <= {20'h0_0000, pd, f_level, ovf_r, chan_r,
                               seq_act_r};
                end
            end
        end
    end

    // Control register and sticky overflow; a new drop beats the clear
    // Limitation: words dropped while the FIFO is full are only flagged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SDL_CTRL_RST;
            ovf_r <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= pwdata[3:0];
            end
            ovf_r <= (push & ~f_in_ready) |
                     (ovf_r & ~(wr_status & pwdata[`SDL_ST_OVF]));
            in_ready <= f_in_ready;
        end
    end
endmodule // sdl_top

// ===== sim/sdl_checker.sv
// Purpose: Bus and output checks for sdl_top
// Assumes: Pin changes settle within a few pclk
// Notes: Hold bound covers sync delay and a slow pixel clock
`timescale 1ns/1ps
module sdl_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire transfer_strobe,
    input wire [9:0] column_output_0,
    input wire [9:0] column_output_1,
    input wire [9:0] column_output_2,
    input wire [9:0] column_output_3,
    input wire [9:0] column_output_4,
    input wire [9:0] column_output_5
);
    wire [59:0] outs = {column_output_5, column_output_4, column_output_3,
        column_output_2, column_output_1, column_output_0};
    wire mapped = (paddr == 8'h00) || (paddr == 8'h04);
    reg [5:0] age_r;
    // Cycles since the last strobe or write; saturates
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            age_r <= 6'h3f;
        else if (transfer_strobe || (pready && pwrite))
            age_r <= 6'h00;
        else if (age_r != 6'h3f)
            age_r <= age_r + 6'h01;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_READY_CAUSE: assert property (pready |-> psel && $past(penable))
        else $error("pready without access");
    AST_ERR_UNMAPPED: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped not refused");
    AST_OK_MAPPED: assert property (pready && mapped |-> !pslverr)
        else $error("mapped refused");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata outside answer");
    AST_ERR_PAIRED: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    AST_OUT_HOLD: assert property (
        !$stable(outs) |-> age_r < 6'h28)
        else $error("outputs moved without transfer");
    AST_PD_CLEAR: assert property (
        pready && pwrite && paddr == 8'h00 && pwdata[2]
        |-> ##[1:4] outs == 60'h000_0000_0000_0000)
        else $error("power-down left data");
    cover property (pready && pslverr);
    cover property (pready && pwrite && pwdata[2]);
    cover property (!$stable(outs));
endmodule // sdl_checker
bind sdl_top sdl_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .transfer_strobe,
    .column_output_0, .column_output_1, .column_output_2,
    .column_output_3, .column_output_4, .column_output_5);

// ===== sim/sdl_ctl_model.sv
// Purpose: Display controller model driving the pixel pins
// Assumes: Caller waits for each task to return
// Notes: Pixel clock stands still between words
`timescale 1ns/1ps
module sdl_ctl_model (
    input wire pclk,
    output logic pix_clk,
    output logic [9:0] pixel_data,
    output logic start_sequence,
    output logic transfer_strobe,
    output logic [2:0] channel_select
);
    initial begin
        pix_clk = 1'b0;
        pixel_data = 10'h000;
        start_sequence = 1'b0;
        transfer_strobe = 1'b0;
        channel_select = 3'h7;
    end
    // One word per edge at half pixel rate; slow pacing lets outputs settle
    task automatic put(input logic lvl, input logic [9:0] d);
        @(posedge pclk);
        pixel_data <= d;
        repeat (4) @(posedge pclk);
        pix_clk <= lvl;
        repeat (4) @(posedge pclk);
        pixel_data <= ~d;
    endtask
    // Own start per device, shared transfer; both static for direct load
    task automatic pins(input logic st, xf, input logic [2:0] sel);
        @(posedge pclk);
        start_sequence <= st;
        transfer_strobe <= xf;
        channel_select <= sel;
        repeat (4) @(posedge pclk);
    endtask
endmodule // sdl_ctl_model

// ===== sim/sdl_top_bench.sv
// Purpose: Self-checking bench for the load sequencer
// Assumes: Controller model paces pixel edges at 9 pclk
// Notes: Each scenario after regs judges outputs before it returns
`timescale 1ns/1ps
module sdl_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_ready;
    logic pix_clk, start_sequence, transfer_strobe, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] pixel_data;
    logic [2:0] channel_select;
    wire [9:0] co [0:5];
    logic [9:0] exp_w [6] = '{6{10'h000}};
    localparam logic [31:0] zero = 32'h0000_0000;
    int num_errors = 0, tests_run = 0;
    sdl_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pix_clk, .pixel_data,
        .start_sequence, .transfer_strobe, .channel_select, .in_ready,
        .column_output_0(co[0]), .column_output_1(co[1]),
        .column_output_2(co[2]), .column_output_3(co[3]),
        .column_output_4(co[4]), .column_output_5(co[5]));
    sdl_ctl_model ctl (.pclk, .pix_clk, .pixel_data, .start_sequence,
        .transfer_strobe, .channel_select);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            num_errors++;
    endtask
    task automatic regs;
        apb(1'b0, 8'h00, zero);
        chk("ctrl reset", 32'h0000_0001, rd);
        apb(1'b1, 8'h08, 32'h0000_000f);
        chk("unmapped err", 32'h0000_0001, err);
        apb(1'b0, 8'h08, zero);
        chk("unmapped data", zero, rd);
        apb(1'b1, 8'h00, 32'h0000_0003);
        apb(1'b0, 8'h00, zero);
        chk("ctrl rw", 32'h0000_0003, rd);
        $display("regs done");
    endtask
    // Twelve-word stream, two spare edges, then a transfer
    task automatic seq(input logic eo, rl, input logic [9:0] b);
        int k;
        apb(1'b1, 8'h00, {30'h0000_0000, rl, eo});
        ctl.pins(1'b1, 1'b0, 3'h7);
        ctl.pins(1'b0, 1'b0, 3'h7);
        for (k = 0; k < 14; k++)
            ctl.put(~k[0], b + 10'(k));
        apb(1'b0, 8'h04, zero);
        chk("seq stopped", zero, rd[0]);
        for (k = 0; k < 6; k++)
            chk("held", exp_w[k], co[k]);
        ctl.pins(1'b0, 1'b1, 3'h7);
        ctl.pins(1'b0, 1'b0, 3'h7);
        ctl.put(1'b1, b);
        ctl.put(1'b0, b);
        repeat (8) @(posedge pclk);
        for (k = 0; k < 6; k++) begin
            exp_w[k] = b + 10'((rl ? 10 - 2 * k : 2 * k) + (eo ? 0 : 1));
            chk("column", exp_w[k], co[k]);
        end
        $display("seq done eo=%0d rl=%0d", eo, rl);
    endtask
    task automatic addr_load;
        int k;
        apb(1'b1, 8'h00, 32'h0000_0001);
        for (k = 0; k < 7; k++) begin
            ctl.pins(1'b1, 1'b1, 3'(k));
            ctl.put(1'b1, 10'h3c0);
            ctl.pins(1'b1, 1'b1, 3'h7 - 3'(k));
            ctl.put(1'b0, 10'h200 + 10'(k));
            if (k < 6)
                exp_w[k] = 10'h200 + 10'(k);
        end
        for (k = 0; k < 6; k++)
            chk("addressed", exp_w[k], co[k]);
        ctl.pins(1'b0, 1'b0, 3'h7);
        $display("addressed done");
    endtask
    task automatic pd;
        int k;
        apb(1'b1, 8'h00, 32'h0000_0005);
        apb(1'b0, 8'h04, zero);
        chk("pd status", 32'h0000_0001, rd[11]);
        for (k = 0; k < 6; k++)
            chk("cleared", zero, co[k]);
        apb(1'b1, 8'h00, 32'h0000_0001);
        ctl.pins(1'b1, 1'b1, 3'h2);
        ctl.put(1'b1, 10'h000);
        ctl.put(1'b0, 10'h155);
        ctl.pins(1'b0, 1'b0, 3'h7);
        chk("resumed", 32'h0000_0155, co[2]);
        chk("stage 1 cleared", zero, co[0]);
        $display("power-down done");
    endtask
    task automatic fifo;
        int k;
        apb(1'b1, 8'h00, 32'h0000_0009);
        ctl.pins(1'b1, 1'b1, 3'h1);
        for (k = 0; k < 34; k++) begin
            ctl.put(1'b1, 10'h000);
            ctl.put(1'b0, 10'(k));
        end
        chk("in_ready", zero, in_ready);
        apb(1'b0, 8'h04, zero);
        chk("level", 32'h0000_0020, rd[10:5]);
        chk("overflow", 32'h0000_0001, rd[4]);
        apb(1'b1, 8'h00, 32'h0000_0001);
        k = 0;
        do begin
            apb(1'b0, 8'h04, zero);
            k++;
        end while (rd[10:5] !== 6'h00 && k < 40);
        chk("drained", zero, rd[10:5]);
        ctl.pins(1'b1, 1'b1, 3'h6);
        ctl.put(1'b1, 10'h000);
        ctl.put(1'b0, 10'h000);
        ctl.pins(1'b0, 1'b0, 3'h7);
        chk("last kept", 32'h0000_001f, co[1]);
        apb(1'b1, 8'h04, 32'h0000_0010);
        apb(1'b0, 8'h04, zero);
        chk("overflow clear", zero, rd[4]);
        $display("fifo done");
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = zero;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        regs;
        seq(1'b1, 1'b0, 10'h100);
        seq(1'b1, 1'b1, 10'h140);
        seq(1'b0, 1'b0, 10'h180);
        seq(1'b0, 1'b1, 10'h1c0);
        addr_load;
        pd;
        fifo;
        finish_test;
    end
    initial begin
        #400000;
        num_errors++;
        finish_test;
    end
endmodule // sdl_top_bench
